// ### verilog/config_response_map.vh
`ifndef CONFIG_RESPONSE_MAP_VH
`define CONFIG_RESPONSE_MAP_VH
// =====================================================
// Datagram types and lengths
`define CMD_GET_CONFIG       16'h3030
`define RSP_GET_CONFIG       16'h3130
`define RSP_HDR_OCTETS       7'h04
`define COMMON_OCTETS        7'h2A
// =====================================================
// Field offsets within the payload
`define OFS_PROTO_REV        7'h00
`define OFS_CLASS_CODE       7'h01
`define OFS_SW_REV           7'h02
`define OFS_IDENT            7'h0A
`define SW_REV_OCTETS        7'h08
`define IDENT_OCTETS         7'h20
// =====================================================
// Value limits and fills
`define FIELD_MIN            8'h01
`define FIELD_MAX            8'hFE
`define EXT_MARKER           8'hFF
`define NUL_FILL             8'h00
`define PROTO_REV_DEFAULT    8'h0B
`define CLASS_CODE_DEFAULT   8'h01
`endif

// ### verilog/octet_sel.v
`timescale 1ns/1ps
`default_nettype none
`include "config_response_map.vh"
// =====================================================
// Picks the payload octet at a given index
module octet_sel (
    input  wire [6:0]   index,        // Payload octet index
    input  wire [7:0]   proto_rev,    // Clamped revision
    input  wire [7:0]   class_code,   // Clamped class code
    input  wire [63:0]  sw_rev,       // Software text, octet 0 in low bits
    input  wire [255:0] ident,        // Vendor text, octet 0 in low bits
    output reg  [7:0]   octet         // Selected octet
);
    reg [6:0] k;
    always @* begin
        k = 7'h00;
        octet = `NUL_FILL;
        if (index == `OFS_PROTO_REV) begin
            octet = proto_rev;
        end else if (index == `OFS_CLASS_CODE) begin
            octet = class_code;
        end else if (index < `OFS_IDENT) begin
            k = index - `OFS_SW_REV;
            octet = sw_rev[k[2:0]*8 +: 8];
        end else if (index < `COMMON_OCTETS) begin
            k = index - `OFS_IDENT;
            octet = ident[k[4:0]*8 +: 8];
        end
    end
endmodule // octet_sel
`default_nettype wire

// ### verilog/config_response_framer.v
`timescale 1ns/1ps
`default_nettype none
`include "config_response_map.vh"
module config_response_framer (
    input  wire         ref_clk,        // 10 MHz clock
    input  wire         reset,          // Async reset, active high
    input  wire         cmd_valid,      // Decoded command present, one cycle
    input  wire [15:0]  cmd_type,       // Decoded command type
    input  wire [15:0]  cmd_length,     // Decoded command payload length
    input  wire [7:0]   proto_rev,      // Revision times ten
    input  wire [7:0]   class_code,     // Equipment class code
    input  wire [63:0]  sw_rev,         // Software text, octet 0 in low bits
    input  wire [255:0] ident,          // Vendor text, octet 0 in low bits
    input  wire [7:0]   extra_length,   // Class specific octet count
    input  wire [7:0]   extra_data,     // Class specific octet
    output wire         extra_ready,    // Class octet consumed this cycle
    output reg          tx_valid,       // Output octet valid
    output reg  [7:0]   tx_data,        // Output octet
    output reg          tx_last,        // Last octet of datagram
    input  wire         tx_ready,       // Downstream accepts octet
    output wire         busy            // Response in progress
);
    localparam S_IDLE   = 3'b001;
    localparam S_COMMON = 3'b010;
    localparam S_EXTRA  = 3'b100;

    reg [2:0]  state;
    reg [6:0]  index;
    reg [7:0]  extra_left;
    reg [7:0]  extra_count;
    reg [15:0] pay_len;
    reg [7:0]  clamp_rev;
    reg [7:0]  clamp_class;
    reg [63:0] sw_clean;
    reg        seen_nul;
    reg [6:0]  common_index;
    wire [7:0] common_octet;
    integer    i;

    // =====================================================
    // Field value conditioning
    // Out-of-range settings are clamped rather than refused, so a bad setting
    // still yields a legal response whose revision and class octets never carry the extension marker
    function [7:0] clamp;
        input [7:0] v;
        begin
            if (v < `FIELD_MIN)
                clamp = `FIELD_MIN;
            else if (v >= `EXT_MARKER)
                clamp = `FIELD_MAX;
            else
                clamp = v;
        end
    endfunction

    always @* begin
        clamp_rev = clamp(proto_rev);
        clamp_class = clamp(class_code);
        // Software text past the first NUL is blanked so its stale characters never reach the console
        seen_nul = 1'b0;
        sw_clean = 64'h0000000000000000;
        for (i = 0; i < 8; i = i + 1) begin
            if (sw_rev[i*8 +: 8] == `NUL_FILL)
                seen_nul = 1'b1;
            sw_clean[i*8 +: 8] = seen_nul ? `NUL_FILL : sw_rev[i*8 +: 8];
        end
    end

    // Header occupies indexes 0..3, payload starts at 4
    always @* begin
        common_index = index - `RSP_HDR_OCTETS;
    end

    // =====================================================
    // Payload octet selection
    octet_sel octet_sel_inst (
        .index      (common_index),
        .proto_rev  (clamp_rev),
        .class_code (clamp_class),
        .sw_rev     (sw_clean),
        .ident      (ident),
        .octet      (common_octet)
    );

    // =====================================================
    // Sequencer
    // Octets in the order they leave on tx_data:
    //   0..1    response type, high octet first
    //   2..3    payload length, high octet first
    //   4       protocol revision
    //   5       class code
    //   6..13   software revision text
    //   14..45  vendor identification text
    //   46..    class specific octets, extra_length of them
    // index runs one ahead of the octet on offer, so it equals END_INDEX while
    // the last common octet waits to be taken.
    localparam [15:0] RSP_TYPE   = `RSP_GET_CONFIG;
    localparam [6:0]  END_INDEX  = `RSP_HDR_OCTETS + `COMMON_OCTETS;
    localparam [6:0]  LAST_INDEX = END_INDEX - 7'h01;

    // Only the configuration query with an empty payload starts a response
    function is_config_query;
        input [15:0] q_type;
        input [15:0] q_len;
        begin
            is_config_query = (q_type == `CMD_GET_CONFIG) && (q_len == 16'h0000);
        end
    endfunction

    // A command that arrives while busy is dropped; the poller must wait for the
    // end of the response before asking again
    wire take = tx_valid & tx_ready;
    wire hit  = cmd_valid && is_config_query(cmd_type, cmd_length);
    wire extra_first;
    wire extra_more;
    assign busy = (state != S_IDLE);

    // Each pulse pops the class octet read at that same edge, so the source only
    // has to show the next one by the following edge
    assign extra_first = (state == S_COMMON) && (index == END_INDEX) && (extra_count != 8'h00);
    assign extra_more  = (state == S_EXTRA) && (extra_left != 8'h01);
    assign extra_ready = take && (extra_first || extra_more);

    // Next octet to present once the current one is taken
    reg [7:0] next_data;
    reg       next_last;
    always @* begin
        next_data = `NUL_FILL;
        next_last = 1'b0;
        case (index)
            7'h00: next_data = RSP_TYPE[15:8];
            7'h01: next_data = RSP_TYPE[7:0];
            7'h02: next_data = pay_len[15:8];
            7'h03: next_data = pay_len[7:0];
            default: begin
                next_data = common_octet;
                next_last = (index == LAST_INDEX) && (extra_count == 8'h00);
            end
        endcase
    end

    // =====================================================
    // Output register
    // tx_data and tx_last move only on a take or when a response opens, so a stalled sink sees them held
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state <= S_IDLE;
            index <= 7'h00;
            extra_left <= 8'h00;
            extra_count <= 8'h00;
            pay_len <= 16'h0000;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            tx_last <= 1'b0;
        end else begin
            case (state)
                S_IDLE: begin
                    if (hit) begin
                        // Extra count latched so the length and stream stay consistent
                        extra_count <= extra_length;
                        pay_len <= {9'h000, `COMMON_OCTETS} + {8'h00, extra_length};
                        index <= 7'h01;
                        tx_valid <= 1'b1;
                        tx_data <= RSP_TYPE[15:8];
                        tx_last <= 1'b0;
                        state <= S_COMMON;
                    end
                end
                S_COMMON: begin
                    if (take) begin
                        if (index == END_INDEX) begin
                            if (extra_count == 8'h00) begin
                                tx_valid <= 1'b0;
                                tx_last <= 1'b0;
                                state <= S_IDLE;
                            end else begin
                                // Class data streams straight through; no staging buffer
                                tx_data <= extra_data;
                                tx_last <= (extra_count == 8'h01);
                                extra_left <= extra_count;
                                state <= S_EXTRA;
                            end
                        end else begin
                            tx_data <= next_data;
                            tx_last <= next_last;
                            index <= index + 7'h01;
                        end
                    end
                end
                S_EXTRA: begin
                    if (take) begin
                        if (extra_left == 8'h01) begin
                            tx_valid <= 1'b0;
                            tx_last <= 1'b0;
                            state <= S_IDLE;
                        end else begin
                            tx_data <= extra_data;
                            tx_last <= (extra_left == 8'h02);
                            extra_left <= extra_left - 8'h01;
                        end
                    end
                end
                default: begin
                    state <= S_IDLE;
                    tx_valid <= 1'b0;
                    tx_last <= 1'b0;
                    index <= 7'h00;
                    extra_left <= 8'h00;
                end
            endcase
        end
    end
endmodule // config_response_framer
`default_nettype wire

// ### dv/config_response_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checker
module config_response_sva (
    input wire logic         ref_clk,      // Clock
    input wire logic         reset,        // Async reset
    input wire logic         cmd_valid,    // Command strobe
    input wire logic [15:0]  cmd_type,     // Command type
    input wire logic [15:0]  cmd_length,   // Command length
    input wire logic [255:0] ident,        // Vendor text
    input wire logic [7:0]   extra_length, // Extra count
    input wire logic         tx_valid,     // Octet valid
    input wire logic [7:0]   tx_data,      // Octet
    input wire logic         tx_last,      // Final octet
    input wire logic         tx_ready,     // Sink ready
    input wire logic         busy          // In progress
);
    logic [8:0]  pos;
    logic        sawnul;
    wire  [15:0] plen = 16'h002A + {8'h00, extra_length};
    wire         beat = tx_valid && tx_ready;
    // Octet position, counted from accepted beats only
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pos <= 9'h000;
            sawnul <= 1'b0;
        end else if (beat) begin
            pos <= tx_last ? 9'h000 : pos + 9'h001;
            sawnul <= !tx_last && (sawnul || (pos >= 9'h006 && pos <= 9'h00D && tx_data == 8'h00));
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    chk_answer_opens: assert property (cmd_valid && !busy && cmd_type == 16'h3030 && cmd_length == 16'h0000
        |=> tx_valid && tx_data == 8'h31 && pos == 9'h000) else $error("response did not open");
    chk_octet_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(tx_last))
        else $error("octet changed while stalled");
    chk_type_low: assert property (tx_valid && pos == 9'h001 |-> tx_data == 8'h30) else $error("type octet");
    chk_length_order: assert property (tx_valid && (pos == 9'h002 || pos == 9'h003)
        |-> tx_data == ((pos == 9'h002) ? plen[15:8] : plen[7:0])) else $error("length octet");
    chk_revision_range: assert property (tx_valid && pos == 9'h004 |-> tx_data inside {[8'h01:8'hFE]})
        else $error("revision out of range");
    chk_class_range: assert property (tx_valid && pos == 9'h005 |-> tx_data inside {[8'h01:8'hFE]})
        else $error("class out of range");
    chk_text_fill: assert property (tx_valid && sawnul && pos > 9'h006 && pos < 9'h00E |-> tx_data == 8'h00)
        else $error("text not filled");
    chk_ident_verbatim: assert property (tx_valid && pos > 9'h00D && pos < 9'h02E
        |-> tx_data == ident[(pos - 9'h00E) * 8 +: 8]) else $error("ident octet");
    chk_last_place: assert property (tx_valid && tx_last |-> pos == 9'h02D + {1'b0, extra_length})
        else $error("last octet misplaced");
endmodule // config_response_sva
bind config_response_framer config_response_sva config_response_sva_inst (.ref_clk, .reset, .cmd_valid,
    .cmd_type, .cmd_length, .ident, .extra_length, .tx_valid, .tx_data, .tx_last, .tx_ready, .busy);
`default_nettype wire

// ### dv/tx_sink.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Polling side: takes octets, stalls every other cycle when slow
module tx_sink (
    input  wire logic       ref_clk,  // Clock
    input  wire logic       reset,    // Async reset
    input  wire logic       slow,     // Stall mode
    input  wire logic       tx_valid, // Octet offered
    input  wire logic [7:0] tx_data,  // Octet
    input  wire logic       tx_last,  // Final octet
    output var  logic       tx_ready, // Octet taken
    output var  logic       rev_one,  // Revision octet is 0x01 or 0x0A
    output var  int         nl_count  // Console line breaks
);
    logic [7:0] rx_mem [0:1023];
    int         rx_n;
    int         fidx;
    logic       phase;
    assign tx_ready = !slow || phase;
    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            phase <= 1'b0;
            rx_n <= 0;
            fidx <= 0;
            rev_one <= 1'b0;
            nl_count <= 0;
        end else begin
            phase <= !phase;
            if (tx_valid && tx_ready) begin
                rx_mem[rx_n] <= tx_data;
                rx_n <= rx_n + 1;
                fidx <= tx_last ? 0 : fidx + 1;
                if (fidx == 4) rev_one <= tx_data == 8'h01 || tx_data == 8'h0A;
                if (fidx > 13 && fidx < 46 && tx_data == 8'h5C) nl_count <= nl_count + 1;
            end
        end
    end
endmodule // tx_sink
`default_nettype wire

// ### dv/tb_config_response_framer.sv
`timescale 1ns/1ps
`default_nettype none
// ==========
// Bench
module tb_config_response_framer;
    logic ref_clk = 1'b0, reset = 1'b1, cmd_valid = 1'b0, slow = 1'b0;
    logic [15:0] cmd_type = 16'h0000, cmd_length = 16'h0000;
    logic [7:0] proto_rev = 8'h0B, class_code = 8'h02, extra_length = 8'h00, extra_data = 8'hA0;
    logic [63:0] sw_rev = 64'h0039_5A00_322E_3156;
    logic [255:0] ident = {232'h0, 24'h42_5C41};
    wire extra_ready, tx_valid, tx_last, tx_ready, busy, rev_one;
    wire [7:0] tx_data;
    int nl_count, fail_count = 0, total_checks = 0, ext_idx = 0;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (extra_ready) ext_idx <= ext_idx + 1;
    always @(negedge ref_clk) extra_data <= 8'hA0 + ext_idx[7:0];
    config_response_framer config_response_framer_inst (.ref_clk, .reset, .cmd_valid, .cmd_type, .cmd_length,
        .proto_rev, .class_code, .sw_rev, .ident, .extra_length, .extra_data, .extra_ready, .tx_valid, .tx_data,
        .tx_last, .tx_ready, .busy);
    tx_sink tx_sink_inst (.ref_clk, .reset, .slow, .tx_valid, .tx_data, .tx_last, .tx_ready, .rev_one, .nl_count);
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    function automatic logic [7:0] clamp(input logic [7:0] v);
        return (v == 8'h00) ? 8'h01 : (v == 8'hFF) ? 8'hFE : v;
    endfunction
    task automatic send(input logic [15:0] ty, input logic [15:0] ln);
        @(negedge ref_clk);
        cmd_valid = 1'b1;
        cmd_type = ty;
        cmd_length = ln;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
    endtask
    // One full response; a second command while busy must be ignored
    task automatic frame();
        int base, n, k;
        logic [7:0] e;
        logic nul;
        base = tx_sink_inst.rx_n;
        n = 46 + extra_length;
        ext_idx = 0;
        send(16'h3030, 16'h0000);
        chk("busy", 16'h0001, {15'h0, busy});
        send(16'h3030, 16'h0000);
        repeat (2000) if (tx_sink_inst.rx_n < base + n) @(negedge ref_clk);
        repeat (3) @(negedge ref_clk);
        chk("octets", 16'(base + n), 16'(tx_sink_inst.rx_n));
        chk("busy", 16'h0000, {15'h0, busy});
        nul = 1'b0;
        for (k = 0; k < n; k++) begin
            if (k < 2) e = k ? 8'h30 : 8'h31;
            else if (k < 4) e = (k == 2) ? 8'((42 + extra_length) >> 8) : 8'(42 + extra_length);
            else if (k < 6) e = clamp((k == 4) ? proto_rev : class_code);
            else if (k < 14) e = nul ? 8'h00 : sw_rev[(k - 6) * 8 +: 8];
            else if (k < 46) e = ident[(k - 14) * 8 +: 8];
            else e = 8'hA0 + 8'(k - 46);
            if (k > 5 && k < 14 && e == 8'h00) nul = 1'b1;
            chk("octet", {8'h00, e}, {8'h00, tx_sink_inst.rx_mem[base + k]});
        end
    endtask
    task automatic t_refused();
        int base;
        base = tx_sink_inst.rx_n;
        send(16'h3031, 16'h0000);
        send(16'h3030, 16'h0001);
        repeat (4) @(negedge ref_clk);
        chk("refused", 16'(base), 16'(tx_sink_inst.rx_n));
        chk("refused busy", 16'h0000, {15'h0, busy});
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        results();
    end
    initial begin
        repeat (5) @(negedge ref_clk);
        chk("reset valid", 16'h0000, {15'h0, tx_valid});
        reset = 1'b0;
        frame();
        chk("line breaks", 16'h0001, 16'(nl_count));
        chk("revision eleven", 16'h0000, {15'h0, rev_one});
        t_refused();
        proto_rev = 8'h00;
        class_code = 8'hFF;
        extra_length = 8'h03;
        slow = 1'b1;
        frame();
        extra_length = 8'hE0;
        frame();
        proto_rev = 8'h0A;
        extra_length = 8'h00;
        frame();
        chk("revision one", 16'h0001, {15'h0, rev_one});
        results();
    end
endmodule // tb_config_response_framer
`default_nettype wire
